/* File: rtl/adcscd_pkg.sv */
`default_nettype none

package adcscd_pkg;

    localparam int FRAME_BITS = 16;
    localparam int CMD_BITS   = 4;
    localparam int CFG_BITS   = 12;
    localparam int CODE_BITS  = 10;
    localparam int PAD_BITS   = FRAME_BITS - CODE_BITS;

    // edge counter reaches this value when the frame is complete
    localparam logic [4:0] EDGE_LAST = 5'h10;
    localparam logic [4:0] CMD_EDGE  = 5'h03;
    localparam logic [4:0] CFG_EDGE  = 5'h0f;

    // command nibble codes
    localparam logic [3:0] CMD_PWRDN  = 4'h8;
    localparam logic [3:0] CMD_CFG_RD = 4'h9;
    localparam logic [3:0] CMD_CFG_WR = 4'ha;
    localparam logic [3:0] CMD_TST_MD = 4'hb;
    localparam logic [3:0] CMD_TST_LO = 4'hc;
    localparam logic [3:0] CMD_TST_HI = 4'hd;
    localparam logic [3:0] CMD_FIFO   = 4'he;
    localparam logic [3:0] CMD_RSVD   = 4'hf;

    // config word fields and reset values
    localparam int          CFG_PSEUDO_BIT = 7;
    localparam int          CFG_TWOS_BIT   = 11;
    localparam logic [11:0] CFG_RESET      = 12'h000;
    localparam logic [9:0]  TWOS_FLIP      = 10'h200;
    localparam logic [2:0]  MINUS_EIGHT_CH = 3'h2;
    localparam logic [2:0]  MINUS_FOUR_CH  = 3'h1;
    localparam logic [2:0]  CHAN_RESET     = 3'h0;

    // pin filter reset levels: {sdi, sclk, fsync, cs_n}
    localparam logic [3:0] PIN_RESET = 4'h3;
    localparam int         PIN_CS    = 0;
    localparam int         PIN_FS    = 1;
    localparam int         PIN_SCLK  = 2;
    localparam int         PIN_SDI   = 3;

    typedef enum logic [1:0] {
        TEST_NONE = 2'h0,
        TEST_MID  = 2'h1,
        TEST_LOW  = 2'h2,
        TEST_HIGH = 2'h3
    } adcscd_test_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_WAIT  = 2'h1,
        ST_SHIFT = 2'h3,
        ST_DONE  = 2'h2
    } adcscd_state_t;

endpackage : adcscd_pkg

`default_nettype wire

/* File: rtl/adcscd_serial_decoder.sv */
// Notes on behaviour
// RULE_01: config bit 7 selects pseudo-differential inputs
// RULE_02: pseudo mode reserves input 2 or 1
// RULE_03: frame is command nibble then twelve bits
// RULE_04: zero-padded trailing bits are accepted
// RULE_05: config read returns config in low bits
// RULE_06: result sits in bits 15 to 6
// RULE_07: binary format maps 000h to 3FFh
// RULE_08: twos complement maps 200h to 1FFh
// RULE_09: chip select start samples on rising clock
// RULE_10: frame sync start samples on falling clock
// RULE_11: host writes zero config after power up
// RULE_12: codes 0-7 select channels, variant dependent
// RULE_13: code 1000b enters software power-down
// RULE_14: code 1001b reads config same frame
// RULE_15: code 1010b loads twelve config bits
// RULE_16: codes 1011b-1101b select test voltages
// RULE_17: code 1110b shifts out oldest FIFO entry
// RULE_18: frame sync fall clears counter, enables input
// RULE_19: output floats outside sixteen bit window
// RULE_20: host reads config only in one-shot mode
// RULE_21: reserved code 1111b is ignored
// RULE_22: odd codes ignored on four-channel variant
`default_nettype none

module adcscd_serial_decoder (
    input  wire logic                 core_clk,         // core clock, 125 MHz
    input  wire logic                 rst,              // async reset, active high
    input  wire logic                 chipSelN,         // chip select pin, active low
    input  wire logic                 frameSyncStrobe,  // frame sync pin
    input  wire logic                 sclkIn,           // serial clock pin
    input  wire logic                 sdiIn,            // serial data in pin
    input  wire logic                 eightChannel,     // variant: 1 eight inputs, 0 four
    input  wire logic [9:0]           convCode,         // straight binary result or FIFO head
    output logic                      sdoOut,           // serial data out value
    output logic                      sdoOeN,           // serial out enable, low drives
    output logic [11:0]               configWord,       // configuration register
    output logic [3:0]                commandNibble,    // last decoded command
    output logic [2:0]                chanSel,          // selected analog channel
    output adcscd_pkg::adcscd_test_t  testSel,          // selected test voltage
    output logic                      pseudoDiff,       // pseudo-differential mode
    output logic [2:0]                minusInput,       // channel used as minus input
    output logic                      swPowerDown,      // software power-down level
    output logic                      fifoReadPulse,    // one-cycle pop of FIFO head
    output logic                      frameBusy         // frame in progress
);

    // three-flop pin filter
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] syncC;
    logic [3:0] pinLvl;
    logic [3:0] pinPrev;
    logic [3:0] next_pinLvl;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_pinLvl[i] = (syncB[i] == syncC[i]) ? syncC[i] : pinLvl[i];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            syncA   <= adcscd_pkg::PIN_RESET;
            syncB   <= adcscd_pkg::PIN_RESET;
            syncC   <= adcscd_pkg::PIN_RESET;
            pinLvl  <= adcscd_pkg::PIN_RESET;
            pinPrev <= adcscd_pkg::PIN_RESET;
        end else begin
            syncA   <= {sdiIn, sclkIn, frameSyncStrobe, chipSelN};
            syncB   <= syncA;
            syncC   <= syncB;
            pinLvl  <= next_pinLvl;
            pinPrev <= pinLvl;
        end
    end

    // one-cycle strobes and the sdi data level from the filtered pin levels
    logic csFall;
    logic csRise;
    logic fsFall;
    logic sclkRise;
    logic sclkFall;
    logic sdiBit;

    assign csFall   = pinPrev[adcscd_pkg::PIN_CS] & ~pinLvl[adcscd_pkg::PIN_CS];
    assign csRise   = ~pinPrev[adcscd_pkg::PIN_CS] & pinLvl[adcscd_pkg::PIN_CS];
    assign fsFall   = pinPrev[adcscd_pkg::PIN_FS] & ~pinLvl[adcscd_pkg::PIN_FS];
    assign sclkRise = ~pinPrev[adcscd_pkg::PIN_SCLK] & pinLvl[adcscd_pkg::PIN_SCLK];
    assign sclkFall = pinPrev[adcscd_pkg::PIN_SCLK] & ~pinLvl[adcscd_pkg::PIN_SCLK];
    assign sdiBit   = pinLvl[adcscd_pkg::PIN_SDI];

    // frame state
    adcscd_pkg::adcscd_state_t state;
    adcscd_pkg::adcscd_state_t next_state;
    logic                      spiMode;
    logic                      next_spiMode;
    logic [4:0]                inCount;
    logic [4:0]                next_inCount;
    logic [4:0]                outCount;
    logic [4:0]                next_outCount;
    logic [15:0]               shiftIn;
    logic [15:0]               next_shiftIn;
    logic [15:0]               outWord;
    logic [15:0]               next_outWord;
    logic                      next_sdoOut;
    logic                      next_sdoOeN;
    logic [11:0]               next_configWord;
    logic [3:0]                next_commandNibble;
    logic [2:0]                next_chanSel;
    adcscd_pkg::adcscd_test_t  next_testSel;
    logic                      next_swPowerDown;
    logic                      next_fifoReadPulse;

    // edge roles swap between chip-select and frame-sync framing
    logic       inSample;
    logic       outChange;
    logic       startFrame;
    logic [3:0] cmdNow;
    logic [2:0] reqChan;
    logic       chanOk;
    logic [9:0] fmtCode;

    always_comb begin
        // hold everything except the FIFO pop, which clears, unless an edge below changes it
        next_state         = state;
        next_spiMode       = spiMode;
        next_inCount       = inCount;
        next_outCount      = outCount;
        next_shiftIn       = shiftIn;
        next_outWord       = outWord;
        next_configWord    = configWord;
        next_commandNibble = commandNibble;
        next_chanSel       = chanSel;
        next_testSel       = testSel;
        next_swPowerDown   = swPowerDown;
        next_fifoReadPulse = 1'b0;
        startFrame         = 1'b0;
        cmdNow             = {shiftIn[2:0], sdiBit};
        reqChan            = 3'h0;
        chanOk             = 1'b0;
        inSample           = spiMode ? sclkRise : sclkFall;   // see RULE_09 see RULE_10
        outChange          = spiMode ? sclkFall : sclkRise;   // see RULE_09 see RULE_10
        // result format conversion
        fmtCode = configWord[adcscd_pkg::CFG_TWOS_BIT] ? (convCode ^ adcscd_pkg::TWOS_FLIP)  // see RULE_08
                                                       : convCode;                            // see RULE_07

        case (state)
            adcscd_pkg::ST_IDLE: begin
                if (csFall) begin
                    if (pinLvl[adcscd_pkg::PIN_FS]) begin
                        next_spiMode = 1'b1;                  // see RULE_09
                        startFrame   = 1'b1;
                    end else begin
                        next_state = adcscd_pkg::ST_WAIT;
                    end
                end
            end
            // chip select low with frame sync low: wait for its fall
            adcscd_pkg::ST_WAIT: begin
                if (csRise) begin
                    next_state = adcscd_pkg::ST_IDLE;
                end else if (fsFall) begin
                    next_spiMode = 1'b0;                      // see RULE_10
                    startFrame   = 1'b1;
                end
            end
            adcscd_pkg::ST_SHIFT: begin
                if (csRise) begin
                    next_state = adcscd_pkg::ST_IDLE;         // see RULE_18
                end else if (!spiMode && fsFall) begin
                    startFrame = 1'b1;                        // see RULE_18
                end else begin
                    if (inSample && inCount != adcscd_pkg::EDGE_LAST) begin
                        next_shiftIn = {shiftIn[14:0], sdiBit};   // see RULE_03
                        next_inCount = inCount + 5'h01;
                        // command decoded as its fourth bit arrives
                        if (inCount == adcscd_pkg::CMD_EDGE) begin
                            next_commandNibble = cmdNow;      // see RULE_03
                            if (cmdNow[3] == 1'b0) begin
                                // see RULE_12 see RULE_22
                                reqChan = eightChannel ? cmdNow[2:0] : {1'b0, cmdNow[2:1]};
                                chanOk  = eightChannel | ~cmdNow[0];
                                // see RULE_02
                                if (configWord[adcscd_pkg::CFG_PSEUDO_BIT] && reqChan == minusInput) begin
                                    chanOk = 1'b0;
                                end
                                if (chanOk) begin
                                    next_chanSel     = reqChan;
                                    next_testSel     = adcscd_pkg::TEST_NONE;
                                    next_swPowerDown = 1'b0;
                                end
                            end else begin
                                case (cmdNow)
                                    adcscd_pkg::CMD_PWRDN: next_swPowerDown = 1'b1;   // see RULE_13
                                    adcscd_pkg::CMD_CFG_RD: begin
                                        next_outWord[11:0] = configWord;              // see RULE_05 see RULE_14
                                    end
                                    adcscd_pkg::CMD_TST_MD: begin
                                        next_testSel     = adcscd_pkg::TEST_MID;      // see RULE_16
                                        next_swPowerDown = 1'b0;
                                    end
                                    adcscd_pkg::CMD_TST_LO: begin
                                        next_testSel     = adcscd_pkg::TEST_LOW;      // see RULE_16
                                        next_swPowerDown = 1'b0;
                                    end
                                    adcscd_pkg::CMD_TST_HI: begin
                                        next_testSel     = adcscd_pkg::TEST_HIGH;     // see RULE_16
                                        next_swPowerDown = 1'b0;
                                    end
                                    adcscd_pkg::CMD_FIFO: next_fifoReadPulse = 1'b1;  // see RULE_17
                                    default: begin
                                        // write waits for its data; reserved does nothing
                                        next_swPowerDown = swPowerDown;               // see RULE_21
                                    end
                                endcase
                            end
                        end
                        // see RULE_15 see RULE_04
                        if (inCount == adcscd_pkg::CFG_EDGE && shiftIn[14:11] == adcscd_pkg::CMD_CFG_WR) begin
                            next_configWord = {shiftIn[10:0], sdiBit};
                        end
                    end
                    if (outChange && outCount != adcscd_pkg::EDGE_LAST) begin
                        next_outCount = outCount + 5'h01;
                    end
                    // done once both sixteen-edge counts are complete
                    if (next_inCount == adcscd_pkg::EDGE_LAST && next_outCount == adcscd_pkg::EDGE_LAST) begin
                        next_state = adcscd_pkg::ST_DONE;
                    end
                end
            end
            adcscd_pkg::ST_DONE: begin
                if (csRise) begin
                    next_state = adcscd_pkg::ST_IDLE;
                end else if (!spiMode && fsFall) begin
                    startFrame = 1'b1;
                end
            end
            default: begin
                next_state = adcscd_pkg::ST_IDLE;
            end
        endcase

        // new frame: counters cleared, result captured for this frame
        // a later change of convCode waits for the next start
        if (startFrame) begin
            next_state    = adcscd_pkg::ST_SHIFT;
            next_inCount  = 5'h00;                                   // see RULE_18
            next_outCount = 5'h00;
            next_shiftIn  = 16'h0000;
            next_outWord  = {fmtCode, {adcscd_pkg::PAD_BITS{1'b0}}}; // see RULE_06 see RULE_17
        end

        // see RULE_19
        // sdo floats once the last bit has had its full period
        next_sdoOeN = ~(next_state == adcscd_pkg::ST_SHIFT && next_outCount != adcscd_pkg::EDGE_LAST);
        next_sdoOut = next_outWord[4'(4'hf - next_outCount[3:0])];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state         <= adcscd_pkg::ST_IDLE;
            spiMode       <= 1'b1;
            inCount       <= 5'h00;
            outCount      <= 5'h00;
            shiftIn       <= 16'h0000;
            outWord       <= 16'h0000;
            sdoOut        <= 1'b0;
            sdoOeN        <= 1'b1;
            configWord    <= adcscd_pkg::CFG_RESET;
            commandNibble <= 4'h0;
            chanSel       <= adcscd_pkg::CHAN_RESET;
            testSel       <= adcscd_pkg::TEST_NONE;
            swPowerDown   <= 1'b0;
            fifoReadPulse <= 1'b0;
        end else begin
            state         <= next_state;
            spiMode       <= next_spiMode;
            inCount       <= next_inCount;
            outCount      <= next_outCount;
            shiftIn       <= next_shiftIn;
            outWord       <= next_outWord;
            sdoOut        <= next_sdoOut;
            sdoOeN        <= next_sdoOeN;
            configWord    <= next_configWord;
            commandNibble <= next_commandNibble;
            chanSel       <= next_chanSel;
            testSel       <= next_testSel;
            swPowerDown   <= next_swPowerDown;
            fifoReadPulse <= next_fifoReadPulse;
        end
    end

    // mode outputs are combinational: pseudoDiff from the register, minusInput from the variant
    assign pseudoDiff = configWord[adcscd_pkg::CFG_PSEUDO_BIT];                      // see RULE_01
    assign minusInput = eightChannel ? adcscd_pkg::MINUS_EIGHT_CH : adcscd_pkg::MINUS_FOUR_CH;
    assign frameBusy  = (state == adcscd_pkg::ST_SHIFT);

endmodule : adcscd_serial_decoder

`default_nettype wire

/* File: verif/adcscd_host_model.sv */
`default_nettype none
module adcscd_host_model (
    input  wire logic core_clk,        // clock
    input  wire logic sdoOut,          // device serial out
    input  wire logic sdoOeN,          // device out enable
    output var logic  chipSelN,        // chip select
    output var logic  frameSyncStrobe, // frame sync
    output var logic  sclkIn,          // serial clock, idle low
    output var logic  sdiIn            // serial data to device
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {chipSelN, frameSyncStrobe, sclkIn, sdiIn} = 4'hc;
    // released data line keeps toggling
    always @(posedge core_clk) if (chipSelN) sdiIn <= ~sdiIn;
    task automatic half();
        repeat (10) @(posedge core_clk);
    endtask : half
    task automatic frame(input logic dsp, input logic [15:0] word, input int nbits, input int stall,
                         output logic [15:0] got, output logic oeAfter);
        got = 16'h0000;
        @(posedge core_clk);
        frameSyncStrobe <= ~dsp;
        half();
        chipSelN <= 1'b0;
        half();
        if (dsp) begin
            sclkIn <= 1'b1;
            frameSyncStrobe <= 1'b1;
            half();
            frameSyncStrobe <= 1'b0;
        end
        sdiIn <= word[15];
        half();
        for (int i = 0; i < nbits; i++) begin
            sclkIn <= ~dsp;
            got[15-i] = sdoOeN ? 1'bz : sdoOut;
            half();
            sclkIn <= dsp;
            if (i < 15) sdiIn <= word[14-i];
            repeat ((i == 7 && stall > 0) ? stall : 0) @(posedge core_clk);
            half();
            if (dsp && i == 7 && stall < 0) begin
                // second frame sync fall restarts the word from its first bit
                frameSyncStrobe <= 1'b1;
                half();
                frameSyncStrobe <= 1'b0;
                sdiIn <= word[15];
                half();
                stall = 0;
                i = -1;
            end
        end
        oeAfter = sdoOeN;
        chipSelN <= 1'b1;
        frameSyncStrobe <= 1'b1;
        half();
        sclkIn <= 1'b0;
        half();
    endtask : frame
endmodule : adcscd_host_model
`default_nettype wire

/* File: verif/adcscd_serial_decoder_asserts.sv */
`default_nettype none
module adcscd_checker (
    input wire logic                     core_clk,      // clock
    input wire logic                     rst,           // reset
    input wire logic                     chipSelN,      // chip select
    input wire logic                     eightChannel,  // variant
    input wire logic                     sdoOeN,        // out enable
    input wire logic [11:0]              configWord,    // config
    input wire logic [3:0]               commandNibble, // command
    input wire logic [2:0]               chanSel,       // channel
    input wire adcscd_pkg::adcscd_test_t testSel,       // test input
    input wire logic                     pseudoDiff,    // pseudo mode
    input wire logic [2:0]               minusInput,    // minus input
    input wire logic                     swPowerDown,   // power-down
    input wire logic                     fifoReadPulse, // fifo pop
    input wire logic                     frameBusy      // frame active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [3:0] csHigh;
    logic [3:0] next_csHigh;
    always_comb next_csHigh = chipSelN ? csHigh + {3'h0, csHigh != 4'hf} : 4'h0;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            csHigh <= 4'h0;
        end else begin
            csHigh <= next_csHigh;
        end
    end
    a_minus_chan: assert property (minusInput == (eightChannel ? 3'h2 : 3'h1))
        else $error("bad minus input");
    a_pseudo_mode: assert property (pseudoDiff == configWord[7]) else $error("bad pseudo mode");
    a_cfg_by_write: assert property ($changed(configWord) |-> commandNibble == 4'ha)
        else $error("config changed without write");
    a_pwr_by_cmd: assert property ($rose(swPowerDown) |-> commandNibble == 4'h8)
        else $error("power-down without command");
    a_test_decode: assert property (
        $changed(testSel) && testSel != adcscd_pkg::TEST_NONE |-> testSel == 2'(commandNibble - 4'ha))
        else $error("bad test select");
    a_chan_decode: assert property (
        $changed(chanSel) && !commandNibble[3] |-> (eightChannel ? chanSel == commandNibble[2:0]
        : !commandNibble[0] && chanSel == {1'b0, commandNibble[2:1]})) else $error("bad channel decode");
    a_fifo_pop: assert property (fifoReadPulse |-> commandNibble == 4'he ##1 !fifoReadPulse)
        else $error("bad fifo pop");
    a_drive_start: assert property ($rose(frameBusy) |-> ##[0:2] !sdoOeN)
        else $error("output not driven at start");
    a_drive_end: assert property ($fell(frameBusy) |-> ##[0:2] sdoOeN)
        else $error("output not released");
    a_idle_float: assert property (csHigh >= 4'h8 |-> sdoOeN && !frameBusy)
        else $error("output driven while deselected");
    a_rsvd_ignore: assert property (
        commandNibble == 4'hf |-> $stable(configWord) && $stable(chanSel) && $stable(swPowerDown))
        else $error("reserved command changed state");
endmodule : adcscd_checker
`default_nettype wire

/* File: verif/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     core_clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     eightChannel = 1'b1;
    logic [9:0]               convCode = 10'h000;
    wire logic                chipSelN, frameSyncStrobe, sclkIn, sdiIn;
    logic                     sdoOut, sdoOeN, pseudoDiff, swPowerDown, fifoReadPulse, frameBusy, oe;
    logic [11:0]              configWord, cfg;
    logic [3:0]               commandNibble;
    logic [2:0]               chanSel, minusInput, expChan;
    adcscd_pkg::adcscd_test_t testSel;
    logic [15:0]              got;
    logic [9:0]               corner [4] = '{10'h000, 10'h3ff, 10'h1ff, 10'h200};
    int                       num_errors = 0;
    int                       total_checks = 0;
    int                       seed = 44399;
    int                       fifoCnt = 0;
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (fifoReadPulse === 1'b1) fifoCnt++;
    adcscd_serial_decoder DUT (
        .core_clk(core_clk), .rst(rst), .chipSelN(chipSelN), .frameSyncStrobe(frameSyncStrobe),
        .sclkIn(sclkIn), .sdiIn(sdiIn), .eightChannel(eightChannel), .convCode(convCode),
        .sdoOut(sdoOut), .sdoOeN(sdoOeN), .configWord(configWord), .commandNibble(commandNibble),
        .chanSel(chanSel), .testSel(testSel), .pseudoDiff(pseudoDiff), .minusInput(minusInput),
        .swPowerDown(swPowerDown), .fifoReadPulse(fifoReadPulse), .frameBusy(frameBusy)
    );
    adcscd_host_model host (
        .core_clk(core_clk), .sdoOut(sdoOut), .sdoOeN(sdoOeN), .chipSelN(chipSelN),
        .frameSyncStrobe(frameSyncStrobe), .sclkIn(sclkIn), .sdiIn(sdiIn)
    );
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    function automatic logic [9:0] fmt(input logic [9:0] c, input logic twos);
        return twos ? (c ^ 10'h200) : c;
    endfunction : fmt
    task automatic send(input logic dsp, input logic [15:0] w, input int n = 16, input int st = 0);
        host.frame(dsp, w, n, st, got, oe);
        if (n == 16) check(oe, 1'b1);
    endtask : send
    task automatic cmd(input logic [3:0] c);
        int f0;
        f0 = fifoCnt;
        send(1'($random(seed)), {c, (c == 4'hf) ? 12'($random(seed)) : 12'h000});
        if (c == 4'ha) cfg = 12'h000;
        if (c < 4'h8 && !(cfg[7] && c == 4'h2) && (eightChannel || !c[0])) begin
            expChan = eightChannel ? c[2:0] : {1'b0, c[2:1]};
        end
        if (c < 4'h8 || c == 4'hf) check({chanSel, configWord}, {expChan, cfg});
        if (c == 4'h8) check(swPowerDown, 1'b1);
        check(commandNibble, c);
        if (c == 4'h9) check(got[11:0], cfg);
        if (c > 4'ha && c < 4'he) check({swPowerDown, testSel}, {1'b0, 2'(c - 4'ha)});
        if (c == 4'he) check(18'(fifoCnt - f0), 18'h1);
        if (c == 4'he) check(got, {fmt(convCode, cfg[11]), 6'h00});
    endtask : cmd
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        check({sdoOeN, swPowerDown, frameBusy, chanSel, configWord}, 18'h20000);
        cfg = 12'h000;
        expChan = 3'h0;
        send(1'b0, 16'ha000);
        check(configWord, cfg);
        for (int i = 0; i < 12; i++) begin
            cfg = 12'($random(seed)) & 12'hf9f;
            if (i < 4) cfg[11] = i[1];
            convCode <= (i < 4) ? corner[i] : 10'($random(seed));
            send(i[0], {4'ha, cfg}, 16, i * 7);
            check({pseudoDiff, configWord}, {cfg[7], cfg});
            send(~i[0], 16'h9000);
            check(got[11:0], cfg);
            send(i[1], 16'h0000);
            check(got, {fmt(convCode, cfg[11]), 6'h00});
        end
        for (int v = 1; v >= 0; v--) begin
            eightChannel <= v[0];
            for (int c = 0; c < 16; c++) cmd(4'(c));
        end
        cfg = 12'($random(seed)) & 12'hf9f;
        send(1'b1, {4'ha, cfg}, 16, -1);
        check(configWord, cfg);
        cfg = 12'h080;
        send(1'b1, 16'ha080);
        cmd(4'h2);
        eightChannel <= 1'b1;
        cmd(4'h2);
        cmd(4'h5);
        send(1'b0, 16'hafff, 8);
        check({sdoOeN, configWord}, {1'b1, cfg});
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        check({sdoOeN, swPowerDown, frameBusy, chanSel, configWord}, 18'h20000);
        stop_test();
    end
    initial begin
        repeat (80000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end
endmodule : tb
bind adcscd_serial_decoder adcscd_checker u_chk (
    .core_clk(core_clk), .rst(rst), .chipSelN(chipSelN), .eightChannel(eightChannel), .sdoOeN(sdoOeN),
    .configWord(configWord), .commandNibble(commandNibble), .chanSel(chanSel), .testSel(testSel),
    .pseudoDiff(pseudoDiff), .minusInput(minusInput), .swPowerDown(swPowerDown),
    .fifoReadPulse(fifoReadPulse), .frameBusy(frameBusy)
);
`default_nettype wire
